// ==== hw/cfg_seq.sv ====
// Power-up, configuration and user-mode sequencer with per-pin open-drain I/O.
// Assumes config beats arrive synchronous to i_clk; i_reconfig is a raw pin.
// Function
// - Full image loaded after every power-up
// - Power-on reset clears state, readies loading
// - Power-on reset ends within 50 us
// - After load: reset registers, enable I/O, run
// - I/O high impedance until initialization done
// - Load plus init is command mode
// - Pin forces reload, reinit, then resume
// - Reconfiguration finishes under 330 ms (code only flags an overrun, does not enforce it)
// - Optional open-drain drives only low
// - Weak pull-up on pins before user mode
`timescale 1ns/1ps
module cfg_seq #(
  parameter int NUM_IO = cfg_seq_pkg::NUM_IO,
  parameter int POR_CYC = cfg_seq_pkg::POR_CYC,
  parameter int RECFG_CYC = cfg_seq_pkg::RECFG_CYC,
  parameter int IMG_DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_reconfig,
  input wire cfg_seq_pkg::cfg_beat_s i_beat,
  input wire logic [NUM_IO-1:0] i_user_out,
  input wire logic [NUM_IO-1:0] i_user_oe,
  input wire logic [NUM_IO-1:0] i_od_sel,
  output logic [NUM_IO-1:0] o_pin_out,
  output logic [NUM_IO-1:0] o_pin_oe,
  output logic [NUM_IO-1:0] o_pin_pullup,
  output logic o_ready_for_cfg,
  output logic o_cmd_mode,
  output logic o_user_mode,
  output logic o_user_rst,
  output logic o_recfg_overrun,
  output logic [7:0] o_img_word
);
  localparam int AW = $clog2(IMG_DEPTH);
  localparam int PW = $clog2(POR_CYC + 1);
  localparam int RW = $clog2(RECFG_CYC + 1);
  localparam int IW = $clog2(cfg_seq_pkg::INIT_CYC + 1);
  // Local copy so the init-length check delays by a plain constant
  localparam int INIT_LEN = cfg_seq_pkg::INIT_CYC;

  // Present state and next state
  cfg_seq_pkg::seq_state_e state;
  cfg_seq_pkg::seq_state_e next_state;
  // Two-stage synchroniser for the pin
  logic rc_meta;
  logic rc_sync;
  // Latched reconfiguration request
  logic rc_req;
  // Phase counters
  logic [PW-1:0] por_cnt;
  logic [IW-1:0] init_cnt;
  logic [RW-1:0] recfg_cnt;
  // Reconfiguration in progress
  logic recfg_run;
  // Image write address
  logic [AW-1:0] waddr;

  // Decode of phase ends
  wire por_done = (por_cnt == PW'(POR_CYC - 1));
  wire init_done = (init_cnt == IW'(cfg_seq_pkg::INIT_CYC - 1));
  wire beat_take = i_beat.valid && (state == cfg_seq_pkg::ST_READY || state == cfg_seq_pkg::ST_LOAD);
  wire load_end = beat_take && i_beat.last;
  wire in_user = (state == cfg_seq_pkg::ST_USER);
  wire recfg_at_max = (recfg_cnt == RW'(RECFG_CYC - 1));

  // Pin sampled through two flops; only the second is read
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
    end else begin
      rc_meta <= i_reconfig;
      rc_sync <= rc_meta;
    end
  end

  // Request held until loading restarts; set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rc_req <= 1'b0;
    end else if (rc_sync && in_user) begin
      rc_req <= 1'b1;
    end else if (state == cfg_seq_pkg::ST_READY) begin
      rc_req <= 1'b0;
    end
  end

  // Next-state selection
  always_comb begin
    next_state = state;
    case (state)
      cfg_seq_pkg::ST_POR: begin
        if (por_done) begin
          next_state = cfg_seq_pkg::ST_READY;
        end
      end
      cfg_seq_pkg::ST_READY: begin
        // Source settles on its own before sending
        if (beat_take) begin
          next_state = i_beat.last ? cfg_seq_pkg::ST_INIT : cfg_seq_pkg::ST_LOAD;
        end
      end
      cfg_seq_pkg::ST_LOAD: begin
        if (load_end) begin
          next_state = cfg_seq_pkg::ST_INIT;
        end
      end
      cfg_seq_pkg::ST_INIT: begin
        if (init_done) begin
          next_state = cfg_seq_pkg::ST_USER;
        end
      end
      cfg_seq_pkg::ST_USER: begin
        if (rc_req || rc_sync) begin
          next_state = cfg_seq_pkg::ST_READY;
        end
      end
      default: begin
        next_state = cfg_seq_pkg::ST_POR;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= cfg_seq_pkg::ST_POR;
    end else begin
      state <= next_state;
    end
  end

  // Power-on interval counter
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      por_cnt <= '0;
    end else if (state == cfg_seq_pkg::ST_POR && !por_done) begin
      por_cnt <= por_cnt + PW'(1);
    end
  end

  // Initialization counter, restarted each load
  always_ff @(posedge i_clk) begin
    if (i_srst || state != cfg_seq_pkg::ST_INIT) begin
      init_cnt <= '0;
    end else if (!init_done) begin
      init_cnt <= init_cnt + IW'(1);
    end
  end

  // Image write address restarts with every load
  always_ff @(posedge i_clk) begin
    if (i_srst || state == cfg_seq_pkg::ST_INIT) begin
      waddr <= '0;
    end else if (beat_take) begin
      waddr <= waddr + AW'(1);
    end
  end

  // Reconfiguration watchdog; flags a stalled source, does not abort
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      recfg_run <= 1'b0;
      recfg_cnt <= '0;
      o_recfg_overrun <= 1'b0;
    end else if (in_user && next_state == cfg_seq_pkg::ST_READY) begin
      recfg_run <= 1'b1;
      recfg_cnt <= '0;
    end else if (recfg_run) begin
      if (in_user) begin
        recfg_run <= 1'b0;
      end else if (recfg_at_max) begin
        o_recfg_overrun <= 1'b1;
      end else begin
        recfg_cnt <= recfg_cnt + RW'(1);
      end
    end
  end

  // Mode flags and user register reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ready_for_cfg <= 1'b0;
      o_cmd_mode <= 1'b1;
      o_user_mode <= 1'b0;
      o_user_rst <= 1'b1;
    end else begin
      o_ready_for_cfg <= (next_state == cfg_seq_pkg::ST_READY);
      o_cmd_mode <= (next_state != cfg_seq_pkg::ST_USER);
      o_user_mode <= (next_state == cfg_seq_pkg::ST_USER);
      o_user_rst <= (next_state != cfg_seq_pkg::ST_USER);
    end
  end

  // Per-pin drive: tri-state in command mode, open-drain optional
  genvar g;
  for (g = 0; g < NUM_IO; g++) begin : g_pin
    wire run = (next_state == cfg_seq_pkg::ST_USER);
    wire od_drive = i_user_oe[g] && !i_user_out[g];
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        o_pin_out[g] <= 1'b0;
        o_pin_oe[g] <= 1'b0;
        o_pin_pullup[g] <= 1'b1;
      end else begin
        o_pin_out[g] <= i_od_sel[g] ? 1'b0 : i_user_out[g];
        o_pin_oe[g] <= run && (i_od_sel[g] ? od_drive : i_user_oe[g]);
        o_pin_pullup[g] <= !run;
      end
    end
  end

  // Loaded image kept in volatile store
  cfg_image_mem #(.DEPTH(IMG_DEPTH), .AW(AW)) u_mem (
    .i_clk(i_clk),
    .i_we(beat_take),
    .i_waddr(waddr),
    .i_wdata(i_beat.data),
    .i_raddr('0),
    .o_rdata(o_img_word)
  );

  // Power-on interval ends on time
  por_len_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(state == cfg_seq_pkg::ST_READY) && $past(state) == cfg_seq_pkg::ST_POR |-> por_cnt == PW'(POR_CYC - 1))
    else $error("power-on interval wrong length");
  // Pins never driven outside user mode
  pin_tristate_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_user_mode |-> o_pin_oe == '0)
    else $error("pin driven in command mode");
  // Open-drain pin never drives high
  od_low_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_pin_oe & $past(i_od_sel) & o_pin_out) == '0)
    else $error("open-drain pin drove high");
  // Pull-up tracks command mode
  pullup_cmd_a: assert property (@(posedge i_clk) disable iff (i_srst)
    o_pin_pullup == {NUM_IO{o_cmd_mode}})
    else $error("pull-up not matching mode");
  // Init phase length before user mode
  init_user_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(state == cfg_seq_pkg::ST_INIT) |-> ##INIT_LEN state == cfg_seq_pkg::ST_USER)
    else $error("init phase wrong length");
  // Modes are exclusive
  mode_excl_a: assert property (@(posedge i_clk) disable iff (i_srst)
    o_cmd_mode != o_user_mode)
    else $error("mode flags overlap");
  // Pin forces command mode promptly
  pin_force_a: assert property (@(posedge i_clk) disable iff (i_srst)
    in_user && rc_sync |=> state == cfg_seq_pkg::ST_READY)
    else $error("reconfig pin ignored");
  // Latched request is cleared only by restart
  req_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(rc_req) |-> $past(state) == cfg_seq_pkg::ST_READY)
    else $error("request dropped early");
  // Watchdog flag only after a long run
  overrun_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(o_recfg_overrun) |-> $past(recfg_at_max) && $past(recfg_run))
    else $error("overrun flagged early");
endmodule : cfg_seq

// ==== inc/cfg_seq_pkg.sv ====
// Package for the power-up and reconfiguration sequencer.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package cfg_seq_pkg;
  // Clock rate
  localparam int CLK_MHZ = 200;
  // Power-on reset interval, longest time in microseconds
  localparam int POR_US = 50;
  // Longest count, rounded down, at least one cycle
  localparam int POR_CYC = (POR_US * CLK_MHZ) < 1 ? 1 : (POR_US * CLK_MHZ);
  // Reconfiguration budget in milliseconds
  localparam int RECFG_MS = 330;
  // Budget in cycles, rounded down
  localparam int RECFG_CYC = RECFG_MS * 1000 * CLK_MHZ;
  // Source settle time, kept by the far side
  localparam int SRC_SETTLE_US = 100;
  // Cycles of the initialization phase
  localparam int INIT_CYC = 4;
  // Default pin count
  localparam int NUM_IO = 8;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_READY = 3'b001,
    ST_LOAD = 3'b010,
    ST_INIT = 3'b011,
    ST_USER = 3'b100
  } seq_state_e;

  // Configuration data beat from the source
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } cfg_beat_s;
endpackage : cfg_seq_pkg

// ==== hw/cfg_image_mem.sv ====
// Small image store holding the loaded configuration words.
// Assumes writes from the sequencer on the same clock; read data is registered.
`timescale 1ns/1ps
module cfg_image_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  // Volatile storage, content lost at power-off
  logic [7:0] mem [DEPTH];

  // Write port and registered read
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : cfg_image_mem

// ==== bench/cfg_src.sv ====
// Model of the configuration source that feeds image beats to the sequencer.
// Assumes the sequencer shows ready once its power-on reset has run.
`timescale 1ns/1ps
module cfg_src #(
  parameter int SETTLE = 30, // Settle wait in cycles, shortened
  parameter int LEN = 4 // Beats in one image
) (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_base,
  input wire logic [15:0] i_gap,
  output cfg_seq_pkg::cfg_beat_s o_beat
);
  int n; // Beat index
  // Idle with nothing valid
  initial o_beat = '0;
  // One whole image per request, only after the settle wait
  always begin
    @(posedge i_go);
    repeat (SETTLE + i_gap) @(posedge i_clk);
    for (n = 0; n < LEN; n++) begin
      #1 o_beat = {1'b1, n == LEN - 1, i_base + 8'(n)};
      @(posedge i_clk);
    end
    // Released: inverted byte so no stale value looks valid
    #1 o_beat = {2'b00, ~o_beat.data};
  end
endmodule : cfg_src

// ==== bench/tb_top.sv ====
// Self-checking bench for the power-up and reconfiguration sequencer.
// Assumes one 200 MHz clock; counts shortened through parameters.
`timescale 1ns/1ps
module tb_top;
  localparam int POR = 20; // Shortened power-on reset
  localparam int BUDGET = 200; // Shortened reconfiguration budget
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic recfg = 1'b0;
  logic go = 1'b0;
  logic [7:0] base = 8'h00;
  logic [15:0] gap = 16'h0000;
  logic [7:0] uout = 8'h00, uoe = 8'h00, ods = 8'h00;
  logic [7:0] pout, poe, ppu, img;
  logic rdy, cmd, usr, urst, ovr;
  cfg_seq_pkg::cfg_beat_s beat;
  int num_errors = 0;
  int tests_run = 0;
  // Clock, 5 ns period
  always #2.5 clk = ~clk;
  cfg_seq #(.NUM_IO(8), .POR_CYC(POR), .RECFG_CYC(BUDGET), .IMG_DEPTH(16)) dut_u (
    .i_clk(clk), .i_srst(srst), .i_reconfig(recfg), .i_beat(beat), .i_user_out(uout),
    .i_user_oe(uoe), .i_od_sel(ods), .o_pin_out(pout), .o_pin_oe(poe), .o_pin_pullup(ppu),
    .o_ready_for_cfg(rdy), .o_cmd_mode(cmd), .o_user_mode(usr), .o_user_rst(urst),
    .o_recfg_overrun(ovr), .o_img_word(img));
  cfg_src src_u (.i_clk(clk), .i_go(go), .i_base(base), .i_gap(gap), .o_beat(beat));
  // Compare and count
  // Wide enough for the 19-bit mode and pin groups
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Step n edges, land just after the last
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Reset state, then ready within the power-on interval
  task t_por;
    int c;
    c = 0;
    chk({cmd, usr, urst, rdy}, 4'b1010);
    chk({poe, ppu}, 16'h00FF);
    srst = 1'b0;
    while (rdy !== 1'b1 && c < 100) begin
      tick(1);
      c++;
    end
    chk(c >= POR - 1 && c <= POR + 2, 1'b1);
  endtask : t_por
  // Whole image load, init phase, then user mode
  task load(input logic [7:0] b, input logic [15:0] g);
    int c;
    c = 0;
    base = b;
    gap = g;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    while (beat.last !== 1'b1 && c < 2000) begin
      tick(1);
      c++;
    end
    // A source that never ends its image counts as a mismatch
    chk(c < 2000, 1'b1);
    tick(1);
    chk({cmd, usr, urst, rdy, poe}, 12'hA00);
    c = 1;
    while (usr !== 1'b1 && c < 50) begin
      tick(1);
      c++;
    end
    chk(c >= cfg_seq_pkg::INIT_CYC && c <= cfg_seq_pkg::INIT_CYC + 2, 1'b1);
    chk({cmd, usr, urst, ppu, img}, {3'b010, 8'h00, b});
  endtask : load
  // Push-pull and open-drain pins side by side
  task t_pins;
    int i;
    for (i = 0; i < 3; i++) begin
      uout = 8'hA5 ^ 8'(i * 51);
      uoe = 8'hF0 ^ 8'(i * 85);
      ods = 8'h3C ^ 8'(i * 17);
      tick(2);
      chk(pout, uout & ~ods);
      chk(poe, (uoe & ~ods) | (uoe & ~uout & ods));
    end
  endtask : t_pins
  // One-cycle pin pulse forces command mode, then reload
  task t_recfg(input logic [7:0] b, input logic [15:0] g, input logic late);
    recfg = 1'b1;
    tick(1);
    recfg = 1'b0;
    tick(2);
    chk({cmd, usr, rdy, poe, ppu}, 19'h500FF);
    load(b, g);
    chk(ovr, late);
  endtask : t_recfg
  // Power cycled in user mode: state and sticky flag cleared, full image again
  task t_repower(input logic [7:0] b);
    srst = 1'b1;
    tick(2);
    chk(ovr, 1'b0);
    t_por();
    load(b, 16'h0000);
  endtask : t_repower
  // Verdict and end of run
  task conclude;
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    tick(16);
    t_por();
    load(8'h10, 16'h0000);
    t_pins();
    t_recfg(8'h40, 16'h0000, 1'b0);
    t_pins();
    t_recfg(8'h70, 16'h00FA, 1'b1);
    t_repower(8'h25);
    t_pins();
    conclude();
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #100us;
    num_errors++;
    conclude();
  end
endmodule : tb_top
